/* File: ovf_timer_pkg.sv */
package ovf_timer_pkg;

	// ==========================================================
	// Register byte offsets on the APB
	// ==========================================================
	localparam logic [7:0] OFS_TIMER_CONTROL  = 8'h00;
	localparam logic [7:0] OFS_COUNT_LOW      = 8'h04;
	localparam logic [7:0] OFS_COUNT_HIGH     = 8'h08;
	localparam logic [7:0] OFS_IRQ_FLAGS      = 8'h0c;
	localparam logic [7:0] OFS_IRQ_ENABLES    = 8'h10;
	localparam logic [7:0] OFS_IRQ_PRIORITIES = 8'h14;
	localparam logic [7:0] OFS_OSC_CONTROL    = 8'h18;

	// ==========================================================
	// Timer control fields
	// ==========================================================
	localparam int BIT_COUNT_ON       = 0;
	localparam int BIT_SOURCE_SELECT  = 1;
	localparam int BIT_SYNC_DISABLE   = 2;
	localparam int BIT_OSC_ENABLE     = 3;
	localparam int BIT_PRESCALE_LO    = 4;
	localparam int BIT_PRESCALE_HI    = 5;
	localparam int BIT_OSC_STATUS     = 6;
	localparam int BIT_WIDE_ACCESS    = 7;

	// Writable control bits; the status bit is never stored
	localparam logic [7:0] CONTROL_WRITE_MASK = 8'hbf;
	localparam logic [7:0] CONTROL_RESET      = 8'h00;

	// ==========================================================
	// Interrupt and oscillator control fields
	// ==========================================================
	localparam int BIT_OVERFLOW       = 0;
	localparam int BIT_IDLE_ON_SLEEP  = 7;
	localparam logic [1:0] SYS_CLOCK_SEL_LOW_POWER = 2'b01;
	localparam logic [7:0] OSC_CONTROL_RESET       = 8'h00;

	// ==========================================================
	// Compare trigger and timing
	// ==========================================================
	localparam logic [3:0] COMPARE_TRIGGER_MODE = 4'hb;
	localparam int         NUM_COMPARE          = 2;
	localparam int         FOSC_PER_INSTR       = 4;
	localparam logic [1:0] INSTR_DIV_LAST       = 2'(FOSC_PER_INSTR - 1);
	localparam logic [15:0] COUNT_MAX           = 16'hffff;

	// Power mode of the device clock
	typedef enum logic [1:0] {
		PM_PRIMARY_RUN,
		PM_SECONDARY_RUN,
		PM_SECONDARY_IDLE
	} power_mode_t;

endpackage

/* File: sixteen_bit_overflow_timer.sv */
// Local design decisions: the APB slave port and the register addresses.
`timescale 1ns/1ps
`default_nettype none
// Notes on behaviour
// - Select code 01 runs everything from oscillator.
// - Sleep with idle bit zero enters secondary idle.
// - Status bit shows oscillator drives system clock.
// - Monitored oscillator failure clears the status bit.
// - Sixteen-bit count increments, wraps max to zero.
// - Wrap latches overflow flag, interrupt when enabled.
// - Enable bit gates overflow flag onto interrupt.
// - Compare mode 1011 trigger clears the count.
// - Compare value then acts as period register.
// - Second compare trigger also starts conversion.
// - Count write beats a same-cycle trigger reset.
// - Trigger reset never sets the overflow flag.
// - Source bit picks instruction cycle or edges.
// - Wide mode buffers high byte through low access.
// - Prescale codes divide by 1, 2, 4, 8.
// - Count-on bit starts and halts counting.
module sixteen_bit_overflow_timer
	import ovf_timer_pkg::*;
(
	input  wire logic        REF_CLK,       // Device clock, 100 MHz
	input  wire logic        NRST,          // Synchronous reset, low
	input  wire logic        PSEL,          // APB select
	input  wire logic        PENABLE,       // APB access phase
	input  wire logic        PWRITE,        // APB direction
	input  wire logic [7:0]  PADDR,         // APB byte address
	input  wire logic [31:0] PWDATA,        // APB write data
	input  wire logic [3:0]  PSTRB,         // APB byte strobes
	output logic             PREADY,        // APB ready
	output logic      [31:0] PRDATA,        // APB read data
	output logic             PSLVERR,       // APB error, unmapped
	input  wire logic        EXT_CLK_IN,    // External count input
	input  wire logic        OSC_CLK_IN,    // Low-power oscillator output
	input  wire logic        OSC_FAIL,      // Oscillator failure seen
	input  wire logic        FAIL_MONITOR_ON, // Clock monitor active
	input  wire logic        SLEEP_EXEC,    // Sleep instruction pulse
	input  wire logic        WAKE_EVENT,    // Wake from idle pulse
	input  wire logic [3:0]  CMP1_MODE,     // First compare mode field
	input  wire logic [15:0] CMP1_VALUE,    // First compare high:low
	input  wire logic        CMP1_USES_TIMER, // First compare on this timer
	input  wire logic [3:0]  CMP2_MODE,     // Second compare mode field
	input  wire logic [15:0] CMP2_VALUE,    // Second compare high:low
	input  wire logic        CMP2_USES_TIMER, // Second compare on this timer
	input  wire logic        ADC_ENABLED,   // Converter is enabled
	output logic             ADC_START,     // Conversion start pulse
	output logic             IRQ,           // Overflow interrupt request
	output logic             IRQ_PRIORITY,  // Priority of that request
	output logic             SEC_RUN,       // Secondary run mode
	output logic             SEC_IDLE,      // Secondary idle mode
	output logic      [15:0] COUNT_VALUE    // Live count
);

	// ==========================================================
	// State
	// ==========================================================
	// Every flop of the block, so reset and update stay in one place
	typedef struct packed {
		logic [15:0]  count;          // Live timer count
		logic [7:0]   high_buffer;    // Wide mode high byte buffer
		logic [2:0]   prescale;       // Input prescaler
		logic [1:0]   instr_div;      // Fosc to instruction cycle
		logic         ext_prev;       // Last sample of count input
		logic [7:0]   control;        // Stored control bits
		logic         overflow_flag;  // Sticky overflow
		logic         overflow_irq_enable;
		logic         overflow_irq_priority;
		logic [1:0]   sys_clock_select;
		logic         idle_on_sleep;
		power_mode_t  mode;           // Power-managed mode
		logic         osc_clock_status;
		logic         ready;          // APB ready flop
		logic [31:0]  rdata;          // APB read data flop
		logic         slverr;         // APB error flop
		logic         adc_start;      // Conversion start pulse
		logic         irq;            // Interrupt output flop
		logic         sec_run;        // Secondary run output flop
		logic         sec_idle;       // Secondary idle output flop
	} state_t;

	state_t st;       // Registered state
	state_t next_st;  // Next state

	// ==========================================================
	// Compare triggers
	// ==========================================================
	logic [3:0]  cmp_mode  [NUM_COMPARE];  // Mode per compare module
	logic [15:0] cmp_value [NUM_COMPARE];  // Value per compare module
	logic        cmp_uses  [NUM_COMPARE];  // Timer selection per module
	logic [NUM_COMPARE-1:0] trig;          // Trigger per module

	assign cmp_mode[0]  = CMP1_MODE;
	assign cmp_mode[1]  = CMP2_MODE;
	assign cmp_value[0] = CMP1_VALUE;
	assign cmp_value[1] = CMP2_VALUE;
	assign cmp_uses[0]  = CMP1_USES_TIMER;
	assign cmp_uses[1]  = CMP2_USES_TIMER;

	// Matching count against compare value makes it the period
	// Also acts in async counting, where software must not rely on it
	genvar gi;
	generate
		for (gi = 0; gi < NUM_COMPARE; gi++) begin : g_cmp
			assign trig[gi] = cmp_uses[gi]
				&& (cmp_mode[gi] == COMPARE_TRIGGER_MODE)
				&& st.control[BIT_COUNT_ON]
				&& (st.count == cmp_value[gi]);
		end
	endgenerate

	// ==========================================================
	// Derived control
	// ==========================================================
	logic       done;        // APB transfer completes this edge
	logic       wr;          // Completing write
	logic       rd;          // Completing read
	logic       src_level;   // Selected count input level
	logic       tick_in;     // One event into the prescaler
	logic [2:0] pre_last;    // Prescaler terminal value
	logic [7:0] wbyte;       // Low byte of write data
	logic       lane0;       // Low byte lane strobed
	logic [7:0] read_byte;   // Addressed register value
	logic       mapped;      // Address hits a register

	// Completion is the access phase with ready already high
	assign done  = PSEL && PENABLE && st.ready;
	assign wr    = done && PWRITE;
	assign rd    = done && !PWRITE;
	assign wbyte = PWDATA[7:0];
	assign lane0 = PSTRB[0];

	// Oscillator path wins the external pin when enabled
	// Switching sources while the new input is high reads as one edge
	assign src_level = st.control[BIT_OSC_ENABLE] ? OSC_CLK_IN : EXT_CLK_IN;

	// ==========================================================
	// Read mux
	// ==========================================================
	// Decoded from the address held through setup and access
	always_comb begin
		mapped    = 1'b1;
		read_byte = 8'h00;
		case (PADDR)
			OFS_TIMER_CONTROL: begin
				// Status bit reads live, never stored
				read_byte = st.control;
				read_byte[BIT_OSC_STATUS] = st.osc_clock_status;
			end
			OFS_COUNT_LOW:  read_byte = st.count[7:0];
			OFS_COUNT_HIGH: begin
				// Wide mode hides the live high byte
				read_byte = st.control[BIT_WIDE_ACCESS] ? st.high_buffer
					: st.count[15:8];
			end
			OFS_IRQ_FLAGS:      read_byte = {7'h00, st.overflow_flag};
			OFS_IRQ_ENABLES:    read_byte = {7'h00, st.overflow_irq_enable};
			OFS_IRQ_PRIORITIES: read_byte = {7'h00, st.overflow_irq_priority};
			OFS_OSC_CONTROL:    read_byte = {st.idle_on_sleep, 5'h00, st.sys_clock_select};
			default:            mapped = 1'b0;
		endcase
	end

	// ==========================================================
	// Next state
	// ==========================================================
	always_comb begin
		next_st = st;
		tick_in = 1'b0;
		pre_last = 3'h0;

		// One wait state keeps read data a clean flop output
		// Ready drops for a cycle after each completion, so no double effect
		next_st.ready  = PSEL && PENABLE && !st.ready;
		next_st.rdata  = {24'h000000, read_byte};
		next_st.slverr = PSEL && PENABLE && !st.ready && !mapped;

		// Instruction cycle is a quarter of the device clock
		// Divider runs free; the first tick after switching on may come early
		next_st.instr_div = st.instr_div + 2'h1;
		next_st.ext_prev  = src_level;

		// Count event from the chosen source
		if (st.control[BIT_SOURCE_SELECT]) begin
			tick_in = src_level && !st.ext_prev;
		end else begin
			tick_in = (st.instr_div == INSTR_DIV_LAST);
		end

		// Prescale code n passes every 2^n-th event
		case (st.control[BIT_PRESCALE_HI:BIT_PRESCALE_LO])
			2'b00:   pre_last = 3'h0;
			2'b01:   pre_last = 3'h1;
			2'b10:   pre_last = 3'h3;
			default: pre_last = 3'h7;
		endcase

		// Counting; halted timer holds count and prescaler
		if (st.control[BIT_COUNT_ON] && tick_in) begin
			if (st.prescale >= pre_last) begin
				next_st.prescale = 3'h0;
				next_st.count    = st.count + 16'h0001;
				if (st.count == COUNT_MAX) begin
					next_st.overflow_flag = 1'b1;
				end
			end else begin
				next_st.prescale = st.prescale + 3'h1;
			end
		end

		// Trigger clears count but leaves the flag alone
		if (|trig) begin
			next_st.count    = 16'h0000;
			next_st.prescale = 3'h0;
		end

		// Conversion start only from the second module
		// Lasts one cycle for each trigger
		next_st.adc_start = trig[1] && ADC_ENABLED;

		// Register writes; a count write beats trigger and tick
		if (wr && lane0) begin
			case (PADDR)
				OFS_TIMER_CONTROL: begin
					// Status position dropped by the mask
					next_st.control = wbyte & CONTROL_WRITE_MASK;
				end
				OFS_COUNT_LOW: begin
					// Low write loads the low byte, the high byte from the buffer in wide mode only, and clears prescaler
					next_st.count[7:0] = wbyte;
					next_st.prescale   = 3'h0;
					if (st.control[BIT_WIDE_ACCESS]) begin
						next_st.count[15:8] = st.high_buffer;
					end
				end
				OFS_COUNT_HIGH: begin
					if (st.control[BIT_WIDE_ACCESS]) begin
						next_st.high_buffer = wbyte;
					end else begin
						next_st.count[15:8] = wbyte;
					end
				end
				OFS_IRQ_FLAGS: begin
					// Hardware set wins over a software clear
					// A clear meeting an overflow in one cycle loses
					next_st.overflow_flag = wbyte[BIT_OVERFLOW] || next_st.overflow_flag
						&& st.overflow_flag == 1'b0 ? wbyte[BIT_OVERFLOW]
						|| next_st.overflow_flag : wbyte[BIT_OVERFLOW];
					if (st.control[BIT_COUNT_ON] && tick_in && st.prescale >= pre_last
						&& st.count == COUNT_MAX) begin
						next_st.overflow_flag = 1'b1;
					end
				end
				OFS_IRQ_ENABLES:    next_st.overflow_irq_enable = wbyte[BIT_OVERFLOW];
				OFS_IRQ_PRIORITIES: next_st.overflow_irq_priority = wbyte[BIT_OVERFLOW];
				OFS_OSC_CONTROL: begin
					next_st.sys_clock_select = wbyte[1:0];
					next_st.idle_on_sleep    = wbyte[BIT_IDLE_ON_SLEEP];
				end
				default: begin
					// Unmapped writes change nothing
				end
			endcase
		end

		// Wide mode low read snapshots the live high byte
		// Taken on the completing edge only, not during the wait state
		if (rd && PADDR == OFS_COUNT_LOW && st.control[BIT_WIDE_ACCESS]) begin
			next_st.high_buffer = st.count[15:8];
		end

		// Power mode follows the clock select and sleep
		// Idle always returns to secondary run, never straight to primary
		case (st.mode)
			PM_PRIMARY_RUN: begin
				if (st.sys_clock_select == SYS_CLOCK_SEL_LOW_POWER) begin
					next_st.mode = PM_SECONDARY_RUN;
				end
			end
			PM_SECONDARY_RUN: begin
				if (st.sys_clock_select != SYS_CLOCK_SEL_LOW_POWER) begin
					next_st.mode = PM_PRIMARY_RUN;
				end else if (SLEEP_EXEC && !st.idle_on_sleep) begin
					next_st.mode = PM_SECONDARY_IDLE;
				end
			end
			PM_SECONDARY_IDLE: begin
				// Only a wake event leaves idle
				if (WAKE_EVENT) begin
					next_st.mode = PM_SECONDARY_RUN;
				end
			end
			default: next_st.mode = PM_PRIMARY_RUN;
		endcase

		// A failed, monitored oscillator no longer drives the clock
		next_st.osc_clock_status = (next_st.mode != PM_PRIMARY_RUN)
			&& !(FAIL_MONITOR_ON && OSC_FAIL);

		// Interrupt is the flag gated by its enable
		next_st.irq = next_st.overflow_flag && next_st.overflow_irq_enable;

		// Mode decodes are registered so every output is a flop
		next_st.sec_run  = (next_st.mode == PM_SECONDARY_RUN);
		next_st.sec_idle = (next_st.mode == PM_SECONDARY_IDLE);
	end

	// ==========================================================
	// Registers
	// ==========================================================
	// Synchronous reset: every pin is already in this clock domain
	always_ff @(posedge REF_CLK) begin
		if (!NRST) begin
			st                     <= '0;
			st.control             <= CONTROL_RESET;
			st.mode                <= PM_PRIMARY_RUN;
		end else begin
			st <= next_st;
		end
	end

	// ==========================================================
	// Outputs
	// ==========================================================
	assign PREADY       = st.ready;
	assign PRDATA       = st.rdata;
	assign PSLVERR      = st.slverr;
	assign ADC_START    = st.adc_start;
	assign IRQ          = st.irq;
	assign IRQ_PRIORITY = st.overflow_irq_priority;
	assign SEC_RUN      = st.sec_run;
	assign SEC_IDLE     = st.sec_idle;
	assign COUNT_VALUE  = st.count;

endmodule // sixteen_bit_overflow_timer
`default_nettype wire

/* File: cmp_sources.sv */
`timescale 1ns/1ps
`default_nettype none
// ==========================================
// Compare trigger sources at the far side
// ==========================================
module cmp_sources
	import ovf_timer_pkg::*;
(
	input  wire logic        arm,        // Trigger reset wanted
	input  wire logic [15:0] period,     // Compare value
	output logic      [3:0]  cmp1_mode,  // First mode field
	output logic      [15:0] cmp1_value, // First compare pair
	output logic             cmp1_uses,  // First on this timer
	output logic      [3:0]  cmp2_mode,  // Second mode field
	output logic      [15:0] cmp2_value, // Second compare pair
	output logic             cmp2_uses   // Second on this timer
);
	// Disarmed: plain compare mode and a flipped value, so no stale match
	assign cmp1_mode  = arm ? COMPARE_TRIGGER_MODE : 4'h2;
	assign cmp2_mode  = arm ? COMPARE_TRIGGER_MODE : 4'h2;
	assign cmp1_value = arm ? period : ~period;
	assign cmp2_value = arm ? period : ~period;
	// Timer stays selected; bench only arms in timer mode
	assign cmp1_uses  = 1'b1;
	assign cmp2_uses  = 1'b1;
endmodule // cmp_sources
`default_nettype wire

/* File: timer_port_checker_sva.sv */
`timescale 1ns/1ps
`default_nettype none
// ==========================================
// Port checker for the overflow timer
// ==========================================
module timer_port_checker
	import ovf_timer_pkg::*;
(
	input wire logic        REF_CLK,
	input wire logic        NRST,
	input wire logic        PSEL,
	input wire logic        PENABLE,
	input wire logic        PWRITE,
	input wire logic        PREADY,
	input wire logic        PSLVERR,
	input wire logic        SLEEP_EXEC,
	input wire logic        ADC_ENABLED,
	input wire logic [3:0]  CMP1_MODE,
	input wire logic [15:0] CMP1_VALUE,
	input wire logic        CMP1_USES_TIMER,
	input wire logic [3:0]  CMP2_MODE,
	input wire logic        CMP2_USES_TIMER,
	input wire logic        ADC_START,
	input wire logic        IRQ,
	input wire logic        SEC_RUN,
	input wire logic        SEC_IDLE,
	input wire logic [15:0] COUNT_VALUE
);
	default clocking cb @(posedge REF_CLK); endclocking
	default disable iff (!NRST);
	// Bus answers after exactly one wait state
	a_ready_wait: assert property (PSEL && PENABLE && !PREADY |=> PREADY) else $error("ready late");
	a_ready_pulse: assert property (PREADY |=> !PREADY) else $error("ready held");
	a_err_ready: assert property (PSLVERR |-> PREADY) else $error("error without ready");
	// Wrap outside bus writes lands on zero
	a_wrap_zero: assert property (!$past(PSEL) && !$past(PSEL, 2) && $past(COUNT_VALUE) == 16'hffff
		&& COUNT_VALUE != 16'hffff |-> COUNT_VALUE == 16'h0000) else $error("bad wrap");
	// Request only drops after software wrote flag or enable
	a_irq_clear: assert property ($fell(IRQ) |-> $past(PSEL && PWRITE, 2)
		|| $past(PSEL && PWRITE, 3)) else $error("irq dropped");
	a_adc_cause: assert property (ADC_START |-> $past(ADC_ENABLED && CMP2_USES_TIMER
		&& CMP2_MODE == COMPARE_TRIGGER_MODE)) else $error("stray start");
	a_trig_noflag: assert property (ADC_START |=> (!$rose(IRQ)) [*2]) else $error("flag on trig");
	// Match in trigger mode clears the count within a few edges
	a_trig_clear: assert property (CMP1_MODE == COMPARE_TRIGGER_MODE && CMP1_USES_TIMER && !PSEL
		&& COUNT_VALUE == CMP1_VALUE |-> ##[1:3] COUNT_VALUE == 16'h0000) else $error("no clear");
	a_idle_cause: assert property ($rose(SEC_IDLE) |-> $past(SEC_RUN) && $past(SLEEP_EXEC))
		else $error("bad idle entry");
	a_mode_excl: assert property (!(SEC_RUN && SEC_IDLE)) else $error("two modes");
endmodule // timer_port_checker
bind sixteen_bit_overflow_timer timer_port_checker u_chk (.REF_CLK, .NRST, .PSEL, .PENABLE,
	.PWRITE, .PREADY, .PSLVERR, .SLEEP_EXEC, .ADC_ENABLED, .CMP1_MODE, .CMP1_VALUE,
	.CMP1_USES_TIMER, .CMP2_MODE, .CMP2_USES_TIMER, .ADC_START, .IRQ, .SEC_RUN, .SEC_IDLE,
	.COUNT_VALUE);
`default_nettype wire

/* File: tb.sv */
`timescale 1ns/1ps
`default_nettype none
// ==========================================
// Bench for the overflow timer
// ==========================================
module tb;
	import ovf_timer_pkg::*;
	logic        ref_clk = 1'b0, nrst = 1'b0;
	logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
	logic [7:0]  paddr = 8'h00;
	logic [31:0] pwdata = 32'h0, prdata, q;
	logic [3:0]  pstrb = 4'hf, c1m, c2m;
	logic        pready, pslverr, adc_start, irq, irq_pri, sec_run, sec_idle, e, c1u, c2u;
	logic        ext = 1'b0, osc = 1'b0, ofail = 1'b0, fmon = 1'b0, slp = 1'b0, wake = 1'b0;
	logic        adc_en = 1'b0, arm = 1'b0;
	logic [15:0] period = 16'h0005, count_value, c1v, c2v, v;
	int          bad_count = 0, tests_run = 0, cycles = 0, n, mx, np;
	always #5 ref_clk = ~ref_clk;
	cmp_sources u_src (.arm(arm), .period(period), .cmp1_mode(c1m), .cmp1_value(c1v),
		.cmp1_uses(c1u), .cmp2_mode(c2m), .cmp2_value(c2v), .cmp2_uses(c2u));
	sixteen_bit_overflow_timer DUT (.REF_CLK(ref_clk), .NRST(nrst), .PSEL(psel),
		.PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PSTRB(pstrb),
		.PREADY(pready), .PRDATA(prdata), .PSLVERR(pslverr), .EXT_CLK_IN(ext),
		.OSC_CLK_IN(osc), .OSC_FAIL(ofail), .FAIL_MONITOR_ON(fmon), .SLEEP_EXEC(slp),
		.WAKE_EVENT(wake), .CMP1_MODE(c1m), .CMP1_VALUE(c1v), .CMP1_USES_TIMER(c1u),
		.CMP2_MODE(c2m), .CMP2_VALUE(c2v), .CMP2_USES_TIMER(c2u), .ADC_ENABLED(adc_en),
		.ADC_START(adc_start), .IRQ(irq), .IRQ_PRIORITY(irq_pri), .SEC_RUN(sec_run),
		.SEC_IDLE(sec_idle), .COUNT_VALUE(count_value));
	// ==========================================
	// Verdict and hang guard
	// ==========================================
	task automatic summarize();
		$display("checks %0d, mismatches %0d", tests_run, bad_count);
		if (bad_count == 0 && tests_run > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
	// A stuck handshake or counter ends here, counted as a mismatch
	always @(posedge ref_clk) begin
		cycles++;
		if (cycles == 20000) begin
			bad_count++;
			summarize();
		end
	end
	task automatic chk(input logic [31:0] g, input logic [31:0] x);
		tests_run++;
		if (g !== x) begin
			bad_count++;
			$display("mismatch at %0t: got %h want %h", $time, g, x);
		end
	endtask
	// ==========================================
	// APB master: hold request until ready seen at an edge
	// ==========================================
	task automatic apb(input logic w, input logic [7:0] a, input logic [7:0] d);
		@(posedge ref_clk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= {24'h000000, d};
		@(posedge ref_clk);
		penable <= 1'b1;
		do @(posedge ref_clk); while (pready !== 1'b1);
		q = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		apb(1'b1, a, d);
	endtask
	task automatic rd(input logic [7:0] a, input logic [7:0] x);
		apb(1'b0, a, 8'h00);
		chk(q, 32'(x));
	endtask
	// Edges between two successive count changes
	task automatic gap();
		@(posedge ref_clk);
		v = count_value;
		while (count_value === v) @(posedge ref_clk);
		v = count_value;
		n = 0;
		do begin
			@(posedge ref_clk);
			n++;
		end while (count_value === v);
	endtask
	// ==========================================
	// Main sequence
	// ==========================================
	initial begin
		repeat (20) @(posedge ref_clk);
		nrst <= 1'b1;
		rd(OFS_TIMER_CONTROL, 8'h00);
		rd(OFS_COUNT_LOW, 8'h00);
		rd(OFS_IRQ_FLAGS, 8'h00);
		apb(1'b0, 8'h1c, 8'h00);
		chk(32'(e), 32'h1);
		// A write with lane 0 unstrobed is dropped without error
		pstrb <= 4'he;
		wr(OFS_IRQ_ENABLES, 8'h01);
		pstrb <= 4'hf;
		chk(32'(e), 32'h0);
		rd(OFS_IRQ_ENABLES, 8'h00);
		wr(OFS_TIMER_CONTROL, 8'hfe);
		rd(OFS_TIMER_CONTROL, 8'hbe);
		for (int k = 0; k < 4; k++) begin
			wr(OFS_TIMER_CONTROL, 8'((k << BIT_PRESCALE_LO) | 1));
			gap();
			chk(32'(n), 32'(FOSC_PER_INSTR << k));
		end
		wr(OFS_TIMER_CONTROL, 8'h00);
		// The edge that stores the control word may still count
		@(posedge ref_clk);
		v = count_value;
		repeat (40) @(posedge ref_clk);
		chk(32'(count_value), 32'(v));
		// Wide mode: high goes via buffer, low read snapshots live high
		wr(OFS_TIMER_CONTROL, 8'h80);
		wr(OFS_COUNT_HIGH, 8'h12);
		wr(OFS_COUNT_LOW, 8'h34);
		wr(OFS_COUNT_HIGH, 8'h56);
		chk(32'(count_value), 32'h1234);
		rd(OFS_COUNT_LOW, 8'h34);
		rd(OFS_COUNT_HIGH, 8'h12);
		// Pin edges count, then oscillator edges count with the pin driven in step
		for (int j = 0; j < 2; j++) begin
			wr(OFS_TIMER_CONTROL, (j == 0) ? 8'h03 : 8'h0b);
			repeat (3) begin
				ext <= 1'b1;
				osc <= (j == 1);
				repeat (3) @(posedge ref_clk);
				ext <= 1'b0;
				osc <= 1'b0;
				repeat (3) @(posedge ref_clk);
			end
			chk(32'(count_value), 32'h1237 + 32'(3 * j));
		end
		// Overflow with request masked, then unmasked, then cleared
		wr(OFS_TIMER_CONTROL, 8'h00);
		wr(OFS_COUNT_HIGH, 8'hff);
		wr(OFS_COUNT_LOW, 8'hfe);
		wr(OFS_TIMER_CONTROL, 8'h01);
		repeat (20) @(posedge ref_clk);
		chk(32'(irq), 32'h0);
		rd(OFS_IRQ_FLAGS, 8'h01);
		wr(OFS_IRQ_ENABLES, 8'h01);
		wr(OFS_IRQ_PRIORITIES, 8'h01);
		repeat (3) @(posedge ref_clk);
		chk(32'({irq, irq_pri}), 32'h3);
		wr(OFS_IRQ_FLAGS, 8'h00);
		repeat (3) @(posedge ref_clk);
		chk(32'(irq), 32'h0);
		// Clock-keeping use: async from the oscillator, only the high byte preloaded with 80
		wr(OFS_TIMER_CONTROL, 8'h0f);
		@(posedge ref_clk);
		v = count_value;
		wr(OFS_COUNT_HIGH, 8'h80);
		@(posedge ref_clk);
		chk(32'(count_value), {16'h0000, 8'h80, v[7:0]});
		// Trigger reset: compare value acts as period, no flag
		wr(OFS_TIMER_CONTROL, 8'h00);
		wr(OFS_COUNT_HIGH, 8'h00);
		wr(OFS_COUNT_LOW, 8'h00);
		for (int j = 0; j < 2; j++) begin
			adc_en <= (j == 0);
			arm <= 1'b1;
			wr(OFS_TIMER_CONTROL, 8'h01);
			mx = 0;
			np = 0;
			repeat (80) begin
				@(posedge ref_clk);
				mx = (int'(count_value) > mx) ? int'(count_value) : mx;
				np += int'(adc_start === 1'b1);
			end
			chk(32'(mx), 32'(period));
			chk(32'(np > 0), 32'(j == 0));
		end
		rd(OFS_IRQ_FLAGS, 8'h00);
		arm <= 1'b0;
		// Low-power oscillator as system clock
		wr(OFS_OSC_CONTROL, 8'h01);
		repeat (3) @(posedge ref_clk);
		chk(32'(sec_run), 32'h1);
		rd(OFS_TIMER_CONTROL, 8'h41);
		fmon <= 1'b1;
		ofail <= 1'b1;
		repeat (3) @(posedge ref_clk);
		rd(OFS_TIMER_CONTROL, 8'h01);
		fmon <= 1'b0;
		ofail <= 1'b0;
		for (int j = 0; j < 2; j++) begin
			slp <= 1'b1;
			@(posedge ref_clk);
			slp <= 1'b0;
			repeat (3) @(posedge ref_clk);
			chk(32'(sec_idle), 32'(j == 0));
			wake <= 1'b1;
			@(posedge ref_clk);
			wake <= 1'b0;
			repeat (3) @(posedge ref_clk);
			chk(32'(sec_run), 32'h1);
			wr(OFS_OSC_CONTROL, 8'h81);
		end
		wr(OFS_OSC_CONTROL, 8'h00);
		repeat (3) @(posedge ref_clk);
		chk(32'(sec_run), 32'h0);
		summarize();
	end
endmodule // tb
`default_nettype wire
